// ===== design/xzt_core.sv
// Decided for this implementation: the Wishbone slave port and the address map.
`timescale 1ns/10ps
// Contract
// - access runs lead, active, trail phases
// - each zone keeps its own timing word
// - read lead: count, doubled when doubler on
// - read active: count(x2) plus waits plus one
// - read trail: count, doubled when doubler on
// - writes use write counts, same formulas
// - wait states counted; zero when ready ignored
// - no legality check on timing settings
// - sync mode samples ready synchronously
// - async mode samples ready through synchroniser
// - strobes, selects change on rising clock only
// - half-rate clock out; access starts rising edge
// - idle holds last address, bit zero high
module xzt_core (
    input  wire logic                          clk_i,                // timing clock
    input  wire logic                          rst_i,                // sync reset, high
    input  wire logic                          ce_i,                 // clock enable
    // register bus, classic wishbone
    input  wire logic                          wb_cyc_i,             // cycle
    input  wire logic                          wb_stb_i,             // strobe
    input  wire logic                          wb_we_i,              // write enable
    input  wire logic [xzt_pkg::WB_AW-1:0]     wb_adr_i,             // byte address
    input  wire logic [3:0]                    wb_sel_i,             // byte selects
    input  wire logic [31:0]                   wb_dat_i,             // write data
    output logic [31:0]                        wb_dat_o,             // read data
    output logic                               wb_ack_o,             // acknowledge
    // access request side
    input  wire logic                          req_valid_i,          // access request
    output logic                               req_ready_o,          // request taken
    input  wire logic                          req_write_i,          // 1 = write
    input  wire logic [xzt_pkg::ZONE_W-1:0]    req_zone_i,           // target zone
    input  wire logic [xzt_pkg::ADDR_W-1:0]    req_addr_i,           // address
    input  wire logic [xzt_pkg::DATA_W-1:0]    req_wdata_i,          // write data
    input  wire logic [xzt_pkg::BE_W-1:0]      req_be_i,             // byte enables
    output logic                               done_o,               // access finished
    output logic [xzt_pkg::DATA_W-1:0]         rdata_o,              // read data
    // external pins
    output logic [xzt_pkg::ADDR_W-1:0]         ext_addr_o,           // address bus
    output logic [xzt_pkg::DATA_W-1:0]         ext_data_o,           // data out
    output logic                               ext_data_oe_n_o,      // data enable, low drives
    input  wire logic [xzt_pkg::DATA_W-1:0]    ext_data_i,           // data in
    output logic                               read_strobe_n_o,      // read strobe
    output logic                               write_strobe_low_n_o, // low byte write strobe
    output logic                               write_strobe_high_n_o,// high byte write strobe
    output logic [xzt_pkg::ZONES-1:0]          zone_select_n_o,      // zone chip selects
    output logic                               interface_clock_out_o,// half-rate clock out
    input  wire logic                          ext_wait_ready_in_i   // external ready
);
    logic [31:0]                    zone_timing_config [xzt_pkg::ZONES];
    xzt_pkg::xzt_phase_e            phase;
    xzt_pkg::xzt_phase_e            next_phase;
    logic [xzt_pkg::ZONE_W-1:0]     zone;
    logic                           write;
    logic [xzt_pkg::BE_W-1:0]       be;
    logic [xzt_pkg::LEN_W-1:0]      cnt;
    logic [xzt_pkg::LEN_W-1:0]      next_cnt;
    logic [xzt_pkg::LEN_W-1:0]      act_len;
    logic [xzt_pkg::LEN_W-1:0]      trail_len;
    logic [xzt_pkg::WS_W-1:0]       inserted_wait_states;
    logic [xzt_pkg::WS_W-1:0]       last_ws;
    logic                           wait_en;
    logic                           clk_div;
    logic                           pend;
    logic                           start;
    logic                           finish;
    logic                           stretch;
    logic                           ready_s;
    logic [xzt_pkg::LEN_W-1:0]      req_lead;
    logic [xzt_pkg::LEN_W-1:0]      req_act;
    logic [xzt_pkg::LEN_W-1:0]      req_trail;
    logic [31:0]                    req_cfg;
    logic                           async_sel;
    logic                           wb_req;
    logic [31:0]                    status_word;
    logic [xzt_pkg::LEN_W-1:0]      lead_len_hold;
    logic [xzt_pkg::ADDR_W-1:0]     addr_hold;

    // register bus
    assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

    genvar gz;
    generate
        for (gz = 0; gz < xzt_pkg::ZONES; gz++)
        begin : g_zone
            localparam logic [7:0] OFF = xzt_pkg::CFG_BASE + 8'(4 * gz);
            always_ff @(posedge clk_i)
            begin
                if (rst_i)
                    zone_timing_config[gz] <= xzt_pkg::CFG_RESET;
                else if (ce_i && wb_req && wb_we_i && wb_adr_i == OFF)
                begin
                    for (int b = 0; b < 4; b++)
                        if (wb_sel_i[b])
                            zone_timing_config[gz][8*b +: 8] <=
                                wb_dat_i[8*b +: 8] & xzt_pkg::CFG_MASK[8*b +: 8];
                end
            end
        end
    endgenerate

    always_comb
    begin
        status_word = 32'h0000_0000;
        status_word[xzt_pkg::ST_BUSY_BIT] = (phase != xzt_pkg::PH_IDLE);
        status_word[xzt_pkg::ST_PHASE_LSB +: 3] = phase;
        status_word[xzt_pkg::ST_ZONE_LSB +: xzt_pkg::ZONE_W] = zone;
        status_word[xzt_pkg::ST_WS_LSB +: xzt_pkg::WS_W] = last_ws;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end
        else if (ce_i)
        begin
            wb_ack_o <= wb_req;
            wb_dat_o <= 32'h0000_0000;
            if (wb_req && !wb_we_i)
            begin
                if (wb_adr_i == xzt_pkg::STATUS_OFF)
                    wb_dat_o <= status_word;
                else if (wb_adr_i[1:0] == 2'b00 &&
                         wb_adr_i < xzt_pkg::CFG_BASE + 8'(4 * xzt_pkg::ZONES))
                    wb_dat_o <= zone_timing_config[wb_adr_i[2 +: xzt_pkg::ZONE_W]];
            end
        end
    end

    // phase lengths of the requested zone, latched when the request is taken
    assign req_cfg = zone_timing_config[req_zone_i];

    xzt_phase_len u_len (
        .cfg_i         (req_cfg),
        .write_i       (req_write_i),
        .lead_len_o    (req_lead),
        .active_base_o (req_act),
        .trail_len_o   (req_trail)
    );

    assign async_sel = zone_timing_config[zone][xzt_pkg::ASYNC_BIT];

    xzt_ready_sample u_rdy (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .ce_i        (ce_i),
        .ready_i     (ext_wait_ready_in_i),
        .async_sel_i (async_sel),
        .ready_o     (ready_s)
    );

    // sequencer; the half-rate clock rises on the edge that starts an access
    assign req_ready_o = ce_i && (phase == xzt_pkg::PH_IDLE) && !pend;
    assign start   = (pend || (phase == xzt_pkg::PH_ALIGN)) && !clk_div;
    assign stretch = wait_en && !ready_s;
    assign finish  = (phase == xzt_pkg::PH_ACTIVE && cnt == 4'h0 && !stretch &&
                      trail_len == 4'h0) ||
                     (phase == xzt_pkg::PH_TRAIL && cnt == 4'h0);

    // lengths used as configured, even zero or below minimum
    always_comb
    begin
        next_phase = phase;
        next_cnt   = cnt;
        case (phase)
            xzt_pkg::PH_IDLE,
            xzt_pkg::PH_ALIGN:
            begin
                if (start)
                begin
                    if (lead_len_hold != 4'h0)
                    begin
                        next_phase = xzt_pkg::PH_LEAD;
                        next_cnt   = lead_len_hold - 4'h1;
                    end
                    else
                    begin
                        next_phase = xzt_pkg::PH_ACTIVE;
                        next_cnt   = act_len - 4'h1;
                    end
                end
                else if (pend)
                    next_phase = xzt_pkg::PH_ALIGN;
            end
            xzt_pkg::PH_LEAD:
            begin
                if (cnt == 4'h0)
                begin
                    next_phase = xzt_pkg::PH_ACTIVE;
                    next_cnt   = act_len - 4'h1;
                end
                else
                    next_cnt = cnt - 4'h1;
            end
            xzt_pkg::PH_ACTIVE:
            begin
                if (cnt != 4'h0)
                    next_cnt = cnt - 4'h1;
                else if (stretch)
                    next_cnt = cnt;
                else if (trail_len != 4'h0)
                begin
                    next_phase = xzt_pkg::PH_TRAIL;
                    next_cnt   = trail_len - 4'h1;
                end
                else
                    next_phase = xzt_pkg::PH_IDLE;
            end
            xzt_pkg::PH_TRAIL:
            begin
                if (cnt == 4'h0)
                    next_phase = xzt_pkg::PH_IDLE;
                else
                    next_cnt = cnt - 4'h1;
            end
            default:
                next_phase = xzt_pkg::PH_IDLE;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pend          <= 1'b0;
            zone          <= '0;
            write         <= 1'b0;
            be            <= '0;
            lead_len_hold <= '0;
            addr_hold     <= '0;
            act_len       <= '0;
            trail_len     <= '0;
            wait_en       <= 1'b0;
        end
        else if (ce_i)
        begin
            if (req_ready_o && req_valid_i)
            begin
                pend          <= 1'b1;
                zone          <= req_zone_i;
                write         <= req_write_i;
                be            <= req_be_i;
                lead_len_hold <= req_lead;
                addr_hold     <= req_addr_i;
                act_len       <= req_act;
                trail_len     <= req_trail;
                wait_en       <= req_cfg[xzt_pkg::WAIT_EN_BIT];
            end
            else if (start)
                pend <= 1'b0;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            phase   <= xzt_pkg::PH_IDLE;
            cnt     <= '0;
            clk_div <= 1'b0;
        end
        else if (ce_i)
        begin
            phase   <= next_phase;
            cnt     <= next_cnt;
            clk_div <= !clk_div;
        end
    end

    // wait states counted only when ready is honoured
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            inserted_wait_states <= '0;
            last_ws              <= '0;
        end
        else if (ce_i)
        begin
            if (start)
                inserted_wait_states <= '0;
            else if (phase == xzt_pkg::PH_ACTIVE && cnt == 4'h0 && stretch &&
                     inserted_wait_states != {xzt_pkg::WS_W{1'b1}})
                inserted_wait_states <= inserted_wait_states + 8'h01;
            if (finish)
                last_ws <= inserted_wait_states;
        end
    end

    // pins registered from the next phase so they move on rising edges only
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ext_addr_o            <= {{(xzt_pkg::ADDR_W-1){1'b0}}, 1'b1};
            ext_data_o            <= '0;
            ext_data_oe_n_o       <= 1'b1;
            read_strobe_n_o       <= 1'b1;
            write_strobe_low_n_o  <= 1'b1;
            write_strobe_high_n_o <= 1'b1;
            zone_select_n_o       <= {xzt_pkg::ZONES{1'b1}};
            rdata_o               <= '0;
            done_o                <= 1'b0;
            interface_clock_out_o <= 1'b0;
        end
        else if (ce_i)
        begin
            interface_clock_out_o <= !clk_div;
            done_o <= finish;
            if (req_ready_o && req_valid_i)
                ext_data_o <= req_wdata_i;
            if (start)
                ext_addr_o <= addr_hold;
            else if (next_phase == xzt_pkg::PH_IDLE ||
                     next_phase == xzt_pkg::PH_ALIGN)
                ext_addr_o[0] <= 1'b1;
            for (int z = 0; z < xzt_pkg::ZONES; z++)
                zone_select_n_o[z] <= !(next_phase != xzt_pkg::PH_IDLE &&
                                        next_phase != xzt_pkg::PH_ALIGN &&
                                        zone == z[xzt_pkg::ZONE_W-1:0]);
            read_strobe_n_o <= !(next_phase == xzt_pkg::PH_ACTIVE && !write);
            write_strobe_low_n_o  <= !(next_phase == xzt_pkg::PH_ACTIVE && write && be[0]);
            write_strobe_high_n_o <= !(next_phase == xzt_pkg::PH_ACTIVE && write && be[1]);
            ext_data_oe_n_o <= !(write && next_phase != xzt_pkg::PH_IDLE &&
                                 next_phase != xzt_pkg::PH_ALIGN);
            if (phase == xzt_pkg::PH_ACTIVE && next_phase != xzt_pkg::PH_ACTIVE && !write)
                rdata_o <= ext_data_i;
        end
    end

endmodule // xzt_core

// ===== design/xzt_phase_len.sv
`timescale 1ns/10ps
module xzt_phase_len (
    input  wire logic [31:0]                  cfg_i,         // zone timing word
    input  wire logic                         write_i,       // 1 = write access
    output logic [xzt_pkg::LEN_W-1:0]         lead_len_o,    // lead cycles
    output logic [xzt_pkg::LEN_W-1:0]         active_base_o, // active cycles without waits
    output logic [xzt_pkg::LEN_W-1:0]         trail_len_o    // trail cycles
);
    logic [xzt_pkg::LEAD_W-1:0]  lead;
    logic [xzt_pkg::ACT_W-1:0]   act;
    logic [xzt_pkg::TRAIL_W-1:0] trail;
    logic                        dbl;

    always_comb
    begin
        if (write_i)
        begin
            lead  = cfg_i[xzt_pkg::WR_LEAD_LSB +: xzt_pkg::LEAD_W];
            act   = cfg_i[xzt_pkg::WR_ACT_LSB +: xzt_pkg::ACT_W];
            trail = cfg_i[xzt_pkg::WR_TRAIL_LSB +: xzt_pkg::TRAIL_W];
        end
        else
        begin
            lead  = cfg_i[xzt_pkg::RD_LEAD_LSB +: xzt_pkg::LEAD_W];
            act   = cfg_i[xzt_pkg::RD_ACT_LSB +: xzt_pkg::ACT_W];
            trail = cfg_i[xzt_pkg::RD_TRAIL_LSB +: xzt_pkg::TRAIL_W];
        end
        dbl = cfg_i[xzt_pkg::DOUBLER_BIT];
    end

    assign lead_len_o    = dbl ? {1'b0, lead, 1'b0} : {2'b00, lead};
    assign active_base_o = (dbl ? {act, 1'b0} : {1'b0, act}) + 4'h1;
    assign trail_len_o   = dbl ? {1'b0, trail, 1'b0} : {2'b00, trail};
endmodule // xzt_phase_len

// ===== design/xzt_ready_sample.sv
`timescale 1ns/10ps
module xzt_ready_sample (
    input  wire logic clk_i,         // timing clock
    input  wire logic rst_i,         // sync reset, high
    input  wire logic ce_i,          // clock enable
    input  wire logic ready_i,       // external ready pin
    input  wire logic async_sel_i,   // 1 = asynchronous sampling
    output logic      ready_o        // sampled ready
);
    logic samp;
    logic sync1;
    logic sync2;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            samp  <= 1'b1;
            sync1 <= 1'b1;
            sync2 <= 1'b1;
        end
        else if (ce_i)
        begin
            samp  <= ready_i;
            sync1 <= ready_i;
            sync2 <= sync1;
        end
    end

    // async path costs one more cycle of latency, hence larger minimums
    assign ready_o = async_sel_i ? sync2 : samp;
endmodule // xzt_ready_sample

// ===== inc/xzt_pkg.sv
package xzt_pkg;

    // external interface geometry
    localparam int ZONES       = 4;
    localparam int ZONE_W      = 2;
    localparam int ADDR_W      = 19;
    localparam int DATA_W      = 16;
    localparam int BE_W        = 2;

    // per-zone timing word layout
    localparam int LEAD_W      = 2;
    localparam int ACT_W       = 3;
    localparam int TRAIL_W     = 2;
    localparam int RD_LEAD_LSB  = 0;
    localparam int RD_ACT_LSB   = 2;
    localparam int RD_TRAIL_LSB = 5;
    localparam int WR_LEAD_LSB  = 8;
    localparam int WR_ACT_LSB   = 10;
    localparam int WR_TRAIL_LSB = 13;
    localparam int DOUBLER_BIT  = 16;
    localparam int WAIT_EN_BIT  = 17;
    localparam int ASYNC_BIT    = 18;

    localparam logic [31:0] CFG_MASK  = 32'h0007_7F7F;
    // slowest timing, ready ignored
    localparam logic [31:0] CFG_RESET = 32'h0001_7F7F;

    // phase lengths and wait-state count
    localparam int LEN_W       = 4;
    localparam int WS_W        = 8;

    // register bus
    localparam int WB_AW       = 8;
    localparam logic [7:0] CFG_BASE   = 8'h00;
    localparam logic [7:0] STATUS_OFF = 8'h10;

    // status word layout
    localparam int ST_BUSY_BIT  = 0;
    localparam int ST_PHASE_LSB = 1;
    localparam int ST_ZONE_LSB  = 4;
    localparam int ST_WS_LSB    = 8;

    typedef enum logic [2:0] {
        PH_IDLE,
        PH_ALIGN,
        PH_LEAD,
        PH_ACTIVE,
        PH_TRAIL
    } xzt_phase_e;

endpackage

// ===== verif/testbench.sv
`timescale 1ns/10ps
module testbench;
    logic                        clk_i = 1'b0;
    logic                        rst_i = 1'b1;
    logic                        cyc = 1'b0, stb = 1'b0, we = 1'b0, valid = 1'b0, wr = 1'b0;
    logic [7:0]                  adr = 8'h00;
    logic [31:0]                 dat_w = 32'h0, dat_r, word;
    logic                        ack, ready, done, oe_n, rd_n, wl_n, wh_n, rdy;
    logic [1:0]                  zone = 2'h0;
    logic [1:0]                  be = 2'h3;
    logic [xzt_pkg::ADDR_W-1:0]  addr = '0, ext_addr;
    logic [15:0]                 wdata = 16'h0, rdata, ext_do, ext_di;
    logic [3:0]                  sel_n;
    logic [3:0]                  mem_wait = 4'h0;
    int                          n_errors = 0, total_checks = 0, n_sel, n_stb, n_hi;

    always #10 clk_i = ~clk_i;

    xzt_core dut_u (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat_w), .wb_dat_o(dat_r),
        .wb_ack_o(ack), .req_valid_i(valid), .req_ready_o(ready), .req_write_i(wr),
        .req_zone_i(zone), .req_addr_i(addr), .req_wdata_i(wdata), .req_be_i(be), .done_o(done),
        .rdata_o(rdata), .ext_addr_o(ext_addr), .ext_data_o(ext_do), .ext_data_oe_n_o(oe_n),
        .ext_data_i(ext_di), .read_strobe_n_o(rd_n), .write_strobe_low_n_o(wl_n),
        .write_strobe_high_n_o(wh_n), .zone_select_n_o(sel_n), .interface_clock_out_o(),
        .ext_wait_ready_in_i(rdy));
    xzt_ext_mem mem_u (.clk_i(clk_i), .addr_i(ext_addr), .data_i(ext_do), .data_o(ext_di),
        .rd_n_i(rd_n), .wr_n_i(wl_n), .sel_n_i(sel_n), .wait_i(mem_wait), .ready_o(rdy));

    task automatic end_sim;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat_w <= d;
        do @(posedge clk_i); while (ack !== 1'b1 && ++n < 50);
        check(ack, 32'h1, "bus ack");
        word = dat_r;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    // counts select and strobe cycles up to the done pulse
    task automatic access(input logic w, input logic [1:0] z, input logic [15:0] d);
        int n = 0;
        @(posedge clk_i);
        valid <= 1'b1;
        wr <= w;
        zone <= z;
        addr <= {17'h0, z};
        wdata <= d;
        do @(posedge clk_i); while (ready !== 1'b1 && ++n < 50);
        valid <= 1'b0;
        n_sel = 0;
        n_stb = 0;
        n_hi = 0;
        do
        begin
            @(posedge clk_i);
            n_sel += (sel_n !== 4'hF) ? 1 : 0;
            n_stb += ((w ? wl_n : rd_n) === 1'b0) ? 1 : 0;
            n_hi += (wh_n === 1'b0) ? 1 : 0;
        end while (done !== 1'b1 && ++n < 150);
        check(done, 32'h1, "access done");
    endtask

    function automatic int sp(input int c, input int dbl);
        return dbl[0] ? 2 * c : c;
    endfunction

    function automatic logic [31:0] cfg(input int rl, ra, rt, wl, wa, wt, md);
        return 32'(rl << xzt_pkg::RD_LEAD_LSB | ra << xzt_pkg::RD_ACT_LSB
            | rt << xzt_pkg::RD_TRAIL_LSB | wl << xzt_pkg::WR_LEAD_LSB | wa << xzt_pkg::WR_ACT_LSB
            | wt << xzt_pkg::WR_TRAIL_LSB | md << xzt_pkg::DOUBLER_BIT);
    endfunction

    task automatic t_reset_regs;
        for (int z = 0; z < 4; z++)
        begin
            wb(1'b0, 8'(4 * z), 32'h0);
            check(word, xzt_pkg::CFG_RESET, "timing word reset");
        end
        wb(1'b1, 8'h20, 32'hFFFF_FFFF);
        wb(1'b0, 8'h20, 32'h0);
        check(word, 32'h0, "unmapped read");
        access(1'b0, 2'h2, 16'h0);
        check(n_sel, 27, "reset read span");
        check(n_stb, 15, "reset read strobe");
    endtask

    task automatic t_zone_timing;
        int t[4][7] = '{'{1, 0, 0, 1, 0, 0, 0}, '{3, 7, 3, 2, 5, 1, 0}, '{2, 3, 1, 1, 6, 2, 1},
            '{0, 0, 0, 0, 0, 0, 0}};
        int r[7];
        logic [31:0] c;
        for (int z = 0; z < 4; z++)
        begin
            r = t[z];
            c = cfg(r[0], r[1], r[2], r[3], r[4], r[5], r[6]);
            wb(1'b1, 8'(4 * z), c);
            wb(1'b0, 8'(4 * z), 32'h0);
            check(word, c, "timing word");
            access(1'b1, 2'(z), 16'hA5C0 + 16'(z));
            check(n_sel, sp(r[3], r[6]) + sp(r[4], r[6]) + 1 + sp(r[5], r[6]), "wr span");
            check(n_stb, sp(r[4], r[6]) + 1, "wr strobe");
            check(n_hi, sp(r[4], r[6]) + 1, "wr high strobe");
            access(1'b0, 2'(z), 16'h0);
            check(n_sel, sp(r[0], r[6]) + sp(r[1], r[6]) + 1 + sp(r[2], r[6]), "rd span");
            check(n_stb, sp(r[1], r[6]) + 1, "rd strobe");
            check(n_hi, 0, "rd high strobe");
            check(rdata, 16'hA5C0 + 16'(z), "read data");
        end
    endtask

    // far side holds ready low; sync, async, then ignored
    task automatic t_wait_states;
        int md[3] = '{2, 6, 0};
        // ready seen one cycle later in sync mode, two in async
        int ns[3] = '{6, 7, 3};
        for (int m = 0; m < 3; m++)
        begin
            mem_wait <= 4'h4;
            wb(1'b1, 8'h04, cfg(2, 2, 0, 2, 2, 0, md[m]));
            access(1'b0, 2'h1, 16'h0);
            wb(1'b0, xzt_pkg::STATUS_OFF, 32'h0);
            check(n_stb, ns[m], "stretched strobe");
            check(word[15:8], ns[m] - 3, "wait count");
            check(word[15:8] == 8'h00, md[m] == 0, "wait inserted");
            check(rdata, 16'hA5C1, "late read data");
        end
        mem_wait <= 4'h0;
    endtask

    initial
    begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset_regs();
        t_zone_timing();
        t_wait_states();
        end_sim();
    end

    initial
    begin
        #400000;
        n_errors++;
        end_sim();
    end
endmodule // testbench

// ===== verif/xzt_ext_mem.sv
`timescale 1ns/10ps
module xzt_ext_mem (
    input  wire logic                        clk_i,   // timing clock
    input  wire logic [xzt_pkg::ADDR_W-1:0]  addr_i,  // address bus
    input  wire logic [xzt_pkg::DATA_W-1:0]  data_i,  // data from device
    output logic      [xzt_pkg::DATA_W-1:0]  data_o,  // data to device
    input  wire logic                        rd_n_i,  // read strobe
    input  wire logic                        wr_n_i,  // write strobe
    input  wire logic [xzt_pkg::ZONES-1:0]   sel_n_i, // zone selects
    input  wire logic [3:0]                  wait_i,  // ready-low cycles
    output logic                             ready_o  // ready, pulled up
);
    logic [15:0] mem [16];
    logic [15:0] last;
    logic [3:0]  held;
    // released bus shows a moving pattern so a stale value never matches
    assign data_o = (!rd_n_i && !(&sel_n_i)) ? mem[addr_i[3:0]] : ~last;
    assign ready_o = (rd_n_i && wr_n_i) || (held >= wait_i);
    always_ff @(posedge clk_i)
    begin
        last <= data_o;
        held <= (rd_n_i && wr_n_i) ? 4'h0 : held + 4'h1;
        if (!wr_n_i && !(&sel_n_i))
            mem[addr_i[3:0]] <= data_i;
    end
endmodule // xzt_ext_mem

// ===== verif/xzt_monitor.sv
`timescale 1ns/10ps
module xzt_monitor (
    input wire logic                        clk_i,                 // timing clock
    input wire logic                        rst_i,                 // sync reset
    input wire logic                        wb_cyc_i,              // bus cycle
    input wire logic                        wb_stb_i,              // bus strobe
    input wire logic                        wb_ack_o,              // bus ack
    input wire logic                        done_o,                // access done
    input wire logic [xzt_pkg::ADDR_W-1:0]  ext_addr_o,            // address bus
    input wire logic                        ext_data_oe_n_o,       // data enable
    input wire logic                        read_strobe_n_o,       // read strobe
    input wire logic                        write_strobe_low_n_o,  // low write strobe
    input wire logic [xzt_pkg::ZONES-1:0]   zone_select_n_o,       // zone selects
    input wire logic                        interface_clock_out_o  // clock out
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    wire sel_idle = &zone_select_n_o;
    sequence s_access_start;
        $fell(sel_idle);
    endsequence
    sequence s_access_end;
        $rose(sel_idle);
    endsequence
    a_one_zone_sel: assert property ($onehot0(~zone_select_n_o))
        else $error("two zone selects low");
    a_strobe_in_sel: assert property (
        !read_strobe_n_o || !write_strobe_low_n_o |-> !sel_idle)
        else $error("strobe outside access");
    a_read_no_drive: assert property (
        !read_strobe_n_o |-> ext_data_oe_n_o && write_strobe_low_n_o)
        else $error("read strobe with write drive");
    a_write_drives: assert property (!write_strobe_low_n_o |-> !ext_data_oe_n_o)
        else $error("write strobe without data drive");
    a_start_on_rise: assert property (s_access_start |-> $rose(interface_clock_out_o))
        else $error("access not on clock out rise");
    a_clk_half: assert property (
        !$past(rst_i) |-> interface_clock_out_o != $past(interface_clock_out_o))
        else $error("clock out not half rate");
    a_idle_addr_bit: assert property (sel_idle |-> ext_addr_o[0])
        else $error("idle address bit zero low");
    a_idle_addr_hold: assert property (sel_idle && $past(sel_idle) |-> $stable(ext_addr_o))
        else $error("idle address moved");
    a_done_after: assert property (s_access_end |-> ##[0:2] done_o)
        else $error("no done after access");
    a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus ack late");
endmodule // xzt_monitor

bind xzt_core xzt_monitor mon_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .done_o(done_o), .ext_addr_o(ext_addr_o),
    .ext_data_oe_n_o(ext_data_oe_n_o), .read_strobe_n_o(read_strobe_n_o),
    .write_strobe_low_n_o(write_strobe_low_n_o), .zone_select_n_o(zone_select_n_o),
    .interface_clock_out_o(interface_clock_out_o));
